// ---- s2tic_pkg.sv ----
// Purpose: Constants for the second sequencer trigger and interrupt control
// Assumes: AXI4-Lite register access, 32-bit data, word-aligned registers
// Notes:   Offsets and reset values named here are used by the design files
package s2tic_pkg;
    // Register byte offsets
    localparam logic [3:0] CTRL_OFFSET   = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam logic [3:0] MASK_OFFSET   = 4'h8;
    localparam logic [3:0] STATE_OFFSET  = 4'hC;
    // Field positions in converter_control_two
    localparam int PWM_B_EN_BIT  = 0;
    localparam int IRQ_MODE_BIT  = 2;
    localparam int IRQ_EN_BIT    = 3;
    localparam int START_BIT     = 5;
    // Field positions in status and mask
    localparam int EV_FLAG_BIT   = 0;
    localparam int EV_LOST_BIT   = 1;
    localparam int EV_WIDTH      = 2;
    // Writable bits of converter_control_two; bits 4 and 1 are reserved
    localparam logic [15:0] CTRL_WMASK = 16'h002D;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [EV_WIDTH-1:0] EV_RESET = 2'h0;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Sequencer interface state
    typedef enum logic [1:0] {
        SEQ_IDLE   = 2'b00,
        SEQ_LAUNCH = 2'b01,
        SEQ_BUSY   = 2'b11
    } s2tic_seq_type;
endpackage : s2tic_pkg

// ---- s2tic_axil.sv ----
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: Address and data of a write may arrive in either order
// Notes:   Presents a one-cycle register write strobe and a read request
`timescale 1ns/1ps
module s2tic_axil (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Register side
    output logic             wr_en,
    output logic [3:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_err,
    output logic [3:0]       rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_err
);
    typedef struct packed {
        logic        aw_have;
        logic [3:0]  awaddr;
        logic        w_have;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        awready;
        logic        wready;
        logic        arready;
    } s2tic_axil_type;

    s2tic_axil_type st_reg;
    s2tic_axil_type st_next;
    logic           do_write;

    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready  = st_reg.wready;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;
    assign do_write      = st_reg.aw_have & st_reg.w_have;
    assign wr_en         = do_write;
    assign wr_addr       = st_reg.awaddr;
    assign wr_data       = st_reg.wdata;
    assign wr_strb       = st_reg.wstrb;
    assign rd_addr       = s_axi_araddr;

    always_comb begin
        st_next = st_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_have = 1'b1;
            st_next.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_have = 1'b1;
            st_next.wdata  = s_axi_wdata;
            st_next.wstrb  = s_axi_wstrb;
        end
        if (do_write) begin
            st_next.aw_have = 1'b0;
            st_next.w_have  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = wr_err ? s2tic_pkg::RESP_SLVERR : s2tic_pkg::RESP_OKAY;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = rd_data;
            st_next.rresp  = rd_err ? s2tic_pkg::RESP_SLVERR : s2tic_pkg::RESP_OKAY;
        end else if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (!aresetn) begin
            st_next = '0;
        end
        // Ready comes from the next state so every bus output leaves a flip-flop
        st_next.awready = ~st_next.aw_have & ~st_next.bvalid & aresetn;
        st_next.wready  = ~st_next.w_have & ~st_next.bvalid & aresetn;
        st_next.arready = ~st_next.rvalid & aresetn;
    end

    always_ff @(posedge aclk) begin
        st_reg <= st_next;
    end
endmodule : s2tic_axil

// ---- s2tic_top.sv ----
// Purpose: Start trigger and interrupt control of the second sequencer
// Assumes: Sequencer busy and end-of-sequence are synchronous to aclk
// Notes:   Registers reached over AXI4-Lite through s2tic_axil
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module s2tic_top (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Converter mode and trigger source
    input  wire logic        dual_sequencer_mode,
    input  wire logic        pwm_conversion_trigger_b,
    // Sequencer handshake
    output logic             second_sequencer_start,
    input  wire logic        second_sequencer_busy,
    input  wire logic        second_sequencer_end,
    // Interrupts
    output logic             second_sequencer_irq,
    output logic             irq
);
    typedef struct packed {
        logic [15:0]                          ctrl;
        logic                                 pending;
        logic                                 half;
        s2tic_pkg::s2tic_seq_type             seq;
        logic                                 start;
        logic                                 flag;
        logic [s2tic_pkg::EV_WIDTH-1:0]       status;
        logic [s2tic_pkg::EV_WIDTH-1:0]       mask;
        logic                                 seq_irq;
        logic                                 irq;
    } s2tic_top_type;

    s2tic_top_type st_reg;
    s2tic_top_type st_next;

    logic        wr_en;
    logic [3:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_err;
    logic [3:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_err;

    s2tic_axil u_axil (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_err        (wr_err),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_err        (rd_err)
    );

    // Decoded write targets
    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;
    logic lo_lane;

    assign lo_lane   = wr_strb[0];
    assign wr_ctrl   = wr_en && wr_addr == s2tic_pkg::CTRL_OFFSET;
    assign wr_status = wr_en && wr_addr == s2tic_pkg::STATUS_OFFSET && lo_lane;
    assign wr_mask   = wr_en && wr_addr == s2tic_pkg::MASK_OFFSET && lo_lane;
    assign wr_err    = !(wr_addr == s2tic_pkg::CTRL_OFFSET || wr_addr == s2tic_pkg::STATUS_OFFSET
                      || wr_addr == s2tic_pkg::MASK_OFFSET || wr_addr == s2tic_pkg::STATE_OFFSET);

    // Read mux; reserved bits are never stored, so they read as zero
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        case (rd_addr)
            s2tic_pkg::CTRL_OFFSET:   rd_data[15:0] = st_reg.ctrl;
            s2tic_pkg::STATUS_OFFSET: rd_data[s2tic_pkg::EV_WIDTH-1:0] = st_reg.status;
            s2tic_pkg::MASK_OFFSET:   rd_data[s2tic_pkg::EV_WIDTH-1:0] = st_reg.mask;
            s2tic_pkg::STATE_OFFSET:  rd_data[3:0] = {st_reg.flag, st_reg.half, st_reg.seq};
            default:                  rd_err = 1'b1;
        endcase
    end

    // Trigger sources
    logic sw_one;
    logic sw_zero;
    logic hw_trig;
    logic trig;
    logic busy;
    logic launch;
    logic flag_set;
    logic [15:0] wmask;

    assign wmask   = {{8{wr_strb[1]}}, {8{wr_strb[0]}}} & s2tic_pkg::CTRL_WMASK;
    assign sw_one  = wr_ctrl && wr_strb[0] && wr_data[s2tic_pkg::START_BIT];
    assign sw_zero = wr_ctrl && wr_strb[0] && !wr_data[s2tic_pkg::START_BIT];
    assign hw_trig = pwm_conversion_trigger_b && st_reg.ctrl[s2tic_pkg::PWM_B_EN_BIT];
    // One event however many sources fire in the cycle
    assign trig    = (sw_one || hw_trig) && dual_sequencer_mode;
    assign busy    = second_sequencer_busy || st_reg.seq != s2tic_pkg::SEQ_IDLE;
    // Flag event of this cycle, so a same-cycle clear cannot hide it from status
    assign flag_set = second_sequencer_end && (!st_reg.ctrl[s2tic_pkg::IRQ_MODE_BIT] || st_reg.half);

    always_comb begin
        st_next = st_reg;
        launch  = 1'b0;
        st_next.start = 1'b0;
        // Stored fields excluding the start bit, which is computed below
        if (wr_ctrl) begin
            st_next.ctrl = (st_reg.ctrl & ~wmask) | (wr_data[15:0] & wmask);
        end
        st_next.ctrl[s2tic_pkg::START_BIT] = st_reg.pending;
        if (sw_zero) begin
            st_next.ctrl[s2tic_pkg::START_BIT] = 1'b0;
        end
        // Pending launches once the sequencer drops back to idle
        case (st_reg.seq)
            s2tic_pkg::SEQ_IDLE: begin
                if (!second_sequencer_busy && st_reg.pending && !sw_zero) begin
                    launch = 1'b1;
                    st_next.ctrl[s2tic_pkg::START_BIT] = 1'b0;
                end else if (trig && !busy && !st_reg.pending) begin
                    launch = 1'b1;
                end else if (trig && busy && !st_reg.pending) begin
                    st_next.ctrl[s2tic_pkg::START_BIT] = 1'b1;
                end
            end
            s2tic_pkg::SEQ_LAUNCH, s2tic_pkg::SEQ_BUSY: begin
                // Busy with bit set: trigger is lost and sets the lost bit in status
                if (trig && !st_reg.pending && !sw_zero) begin
                    st_next.ctrl[s2tic_pkg::START_BIT] = 1'b1;
                end
            end
            default: begin
                st_next.seq = s2tic_pkg::SEQ_IDLE;
            end
        endcase
        st_next.pending = st_next.ctrl[s2tic_pkg::START_BIT];
        // Sequencer tracking: launch, then wait for it to report busy and finish
        case (st_reg.seq)
            s2tic_pkg::SEQ_IDLE:   if (launch) st_next.seq = s2tic_pkg::SEQ_LAUNCH;
            s2tic_pkg::SEQ_LAUNCH: if (second_sequencer_busy) st_next.seq = s2tic_pkg::SEQ_BUSY;
                                   else if (second_sequencer_end) st_next.seq = s2tic_pkg::SEQ_IDLE;
            s2tic_pkg::SEQ_BUSY:   if (!second_sequencer_busy || second_sequencer_end)
                                       st_next.seq = s2tic_pkg::SEQ_IDLE;
            default:               st_next.seq = s2tic_pkg::SEQ_IDLE;
        endcase
        st_next.start = launch;
        // Every-other mode counts ends in a half flag
        if (second_sequencer_end) begin
            if (st_reg.ctrl[s2tic_pkg::IRQ_MODE_BIT]) begin
                st_next.half = ~st_reg.half;
                if (st_reg.half) begin
                    st_next.flag = 1'b1;
                end
            end else begin
                st_next.half = 1'b0;
                st_next.flag = 1'b1;
            end
        end
        // Status: set wins over write-one-to-clear
        if (wr_status) begin
            st_next.status = st_reg.status & ~wr_data[s2tic_pkg::EV_WIDTH-1:0];
            st_next.flag   = st_next.flag & ~(wr_data[s2tic_pkg::EV_FLAG_BIT] && !flag_set);
        end
        if (flag_set) begin
            st_next.status[s2tic_pkg::EV_FLAG_BIT] = 1'b1;
        end
        if (trig && busy && st_reg.pending) begin
            st_next.status[s2tic_pkg::EV_LOST_BIT] = 1'b1;
        end
        if (wr_mask) begin
            st_next.mask = wr_data[s2tic_pkg::EV_WIDTH-1:0];
        end
        st_next.seq_irq = st_next.flag && st_next.ctrl[s2tic_pkg::IRQ_EN_BIT];
        st_next.irq     = |(st_next.status & st_next.mask);
        if (!aresetn) begin
            st_next.ctrl    = s2tic_pkg::CTRL_RESET;
            st_next.pending = 1'b0;
            st_next.half    = 1'b0;
            st_next.seq     = s2tic_pkg::SEQ_IDLE;
            st_next.start   = 1'b0;
            st_next.flag    = 1'b0;
            st_next.status  = s2tic_pkg::EV_RESET;
            st_next.mask    = s2tic_pkg::EV_RESET;
            st_next.seq_irq = 1'b0;
            st_next.irq     = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        st_reg <= st_next;
    end

    assign second_sequencer_start = st_reg.start;
    assign second_sequencer_irq   = st_reg.seq_irq;
    assign irq                    = st_reg.irq;
endmodule : s2tic_top

// ---- s2tic_properties.sv ----
// Purpose: Port assertions for the second sequencer trigger block
// Assumes: One clock domain, reset synchronous and active low
// Notes:   Bound to s2tic_top from the testbench top file
`timescale 1ns/1ps
module s2tic_properties (
    // Clock, reset and mode
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        dual_sequencer_mode,
    // Sequencer
    input  wire logic        second_sequencer_start,
    input  wire logic        second_sequencer_busy,
    // Bus
    input  wire logic        s_axi_awready,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    start_pulse_a: assert property (second_sequencer_start |=> !second_sequencer_start)
        else $error("start pulse longer than one cycle");
    busy_blocks_a: assert property (second_sequencer_busy |=> !second_sequencer_start)
        else $error("start issued while sequencer busy");
    cascade_quiet_a: assert property (second_sequencer_start |-> $past(dual_sequencer_mode))
        else $error("start issued in cascaded mode");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken during response");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken during response");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    cover property (second_sequencer_start);
    cover property (second_sequencer_busy ##1 !second_sequencer_busy);
    cover property (s_axi_rvalid && s_axi_rready);
endmodule : s2tic_properties

// ---- s2tic_seq_model.sv ----
// Purpose: Far side model: sequencer busy and end, trigger B source
// Assumes: Sequence length fixed by HOLD, one clock
// Notes:   Trigger B is a one-cycle pulse one edge after fire
`timescale 1ns/1ps
module s2tic_seq_model #(parameter int HOLD = 40) (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Sequencer side
    input  wire logic start,
    output logic      busy,
    output logic      seq_end,
    // Trigger source
    input  wire logic fire,
    output logic      pwm_trig
);
    int cnt;
    always @(posedge aclk) begin
        seq_end <= 1'b0;
        pwm_trig <= aresetn && fire;
        if (!aresetn) begin
            busy <= 1'b0;
            cnt <= 0;
        end else if (start) begin
            busy <= 1'b1;
            cnt <= HOLD;
        end else if (busy) begin
            cnt <= cnt - 1;
            // Busy falls together with the end pulse, as the tracker expects
            if (cnt == 1) begin
                busy <= 1'b0;
                seq_end <= 1'b1;
            end
        end
    end
endmodule : s2tic_seq_model

// ---- test_second_sequencer_trigger_and_irq_control.sv ----
// Purpose: Self-checking bench for the second sequencer trigger block
// Assumes: Model sequence of 40 cycles outlasts the bus traffic in a test
// Notes:   Byte lanes always all enabled
`timescale 1ns/1ps
`define CHK(act, exp) begin n_compared++; if ((act) !== (exp)) begin fail_count++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (act), (exp)); end end
module test_second_sequencer_trigger_and_irq_control;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        dual = 1'b0, fire = 1'b0, pwm, start, busy, send, ssirq, irq;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, b, r;
    int          fail_count = 0, n_compared = 0, n_start = 0, cyc = 0, n0;
    always #5 aclk = ~aclk;
    s2tic_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dual_sequencer_mode(dual),
        .pwm_conversion_trigger_b(pwm), .second_sequencer_start(start), .second_sequencer_busy(busy),
        .second_sequencer_end(send), .second_sequencer_irq(ssirq), .irq(irq));
    s2tic_seq_model #(.HOLD(40)) model_u (.aclk(aclk), .aresetn(aresetn), .start(start), .busy(busy),
        .seq_end(send), .fire(fire), .pwm_trig(pwm));
    always @(posedge aclk) begin
        if (start === 1'b1) n_start++;
        cyc++;
        // Ceiling well above the several hundred cycles the tests need
        if (cyc == 6000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        {awaddr, wdata} <= {a, d};
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        b = bresp;
        bready <= 1'b0;
        // One idle edge so a following call never re-raises bready in this step
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    task automatic wait_idle();
        repeat (3) @(posedge aclk);
        while (busy) @(posedge aclk);
        repeat (2) @(posedge aclk);
    endtask : wait_idle
    task automatic pulse();
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask : pulse
    task automatic t_regs();
        rd(4'h0); `CHK(v, 32'h0)
        rd(4'hC); `CHK(v, 32'h0)
        wr(4'h0, 32'hFFFF_FFFF);
        wait_idle();
        rd(4'h0); `CHK(v, 32'h0000_000D)
        `CHK(n_start, 0)
        pulse();
        `CHK(n_start, 0)
        wr(4'h0, 32'h0);
        wr(4'h8, 32'h3);
        rd(4'h8); `CHK(v, 32'h3)
        dual <= 1'b1;
    endtask : t_regs
    task automatic t_irq();
        wr(4'h0, 32'h2C);
        wait_idle();
        `CHK(ssirq, 1'b0)
        wr(4'h0, 32'h2C);
        wait_idle();
        `CHK(ssirq, 1'b1)
        `CHK(irq, 1'b1)
        wr(4'h4, 32'h3);
        repeat (2) @(posedge aclk);
        `CHK(ssirq, 1'b0)
        wr(4'h0, 32'h20);
        wait_idle();
        `CHK(ssirq, 1'b0)
        `CHK(irq, 1'b1)
        wr(4'h4, 32'h3);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0)
    endtask : t_irq
    task automatic t_pending();
        n0 = n_start;
        wr(4'h0, 32'h21);
        repeat (3) @(posedge aclk);
        `CHK(busy, 1'b1)
        pulse();
        rd(4'h0); `CHK(v, 32'h21)
        pulse();
        rd(4'h4); `CHK(v, 32'h2)
        wait_idle();
        wait_idle();
        `CHK(n_start, n0 + 2)
        rd(4'h0); `CHK(v, 32'h1)
        wr(4'h4, 32'h3);
    endtask : t_pending
    task automatic t_cancel();
        n0 = n_start;
        wr(4'h0, 32'h20);
        repeat (3) @(posedge aclk);
        wr(4'h0, 32'h20);
        rd(4'h0); `CHK(v, 32'h20)
        wr(4'h0, 32'h0);
        rd(4'h0); `CHK(v, 32'h0)
        `CHK(busy, 1'b1)
        wait_idle();
        wait_idle();
        `CHK(n_start, n0 + 1)
    endtask : t_cancel
    task automatic t_pwm_enable();
        n0 = n_start;
        pulse();
        wait_idle();
        `CHK(n_start, n0)
        wr(4'h0, 32'h1);
        pulse();
        wait_idle();
        `CHK(n_start, n0 + 1)
    endtask : t_pwm_enable
    // Unmapped address is refused, then software and trigger B land in one cycle
    task automatic t_both();
        n0 = n_start;
        wr(4'h2, 32'h21); `CHK(b, s2tic_pkg::RESP_SLVERR)
        rd(4'h2); `CHK(r, s2tic_pkg::RESP_SLVERR)
        `CHK(n_start, n0)
        fire <= 1'b1;
        fork
            wr(4'h0, 32'h21);
            begin
                @(posedge aclk);
                fire <= 1'b0;
            end
        join
        `CHK(b, s2tic_pkg::RESP_OKAY)
        wait_idle();
        wait_idle();
        `CHK(n_start, n0 + 1)
        rd(4'h0); `CHK(v, 32'h1)
        rd(4'h4); `CHK(v[1], 1'b0)
    endtask : t_both
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_irq();
        t_pending();
        t_cancel();
        t_pwm_enable();
        t_both();
        close_out();
    end
endmodule : test_second_sequencer_trigger_and_irq_control
bind s2tic_top s2tic_properties chk_u (.aclk(aclk), .aresetn(aresetn), .dual_sequencer_mode(dual_sequencer_mode),
    .second_sequencer_start(second_sequencer_start), .second_sequencer_busy(second_sequencer_busy),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
